// file: rtcmh_counters.sv
// Minute and hour BCD counters with Avalon-MM register access
// Operation
// - Minute counter advances on each minute carry
// - Minute counter holds only 00 to 59
// - Minute units step 0-9, wrap carries tens
// - Minute tens count 0 through 5
// - Bit 7 reads busy during updates
// - Hour counter advances on each hour carry
// - Hour range 00-11 or 00-23 by mode
// - Hour units step 0-9, wrap carries tens
// - Hour tens count only 0 through 2
// - Hour bit 6 always reads 0
// - Mode 0 runs 0-11, mode 1 0-23
// - Hour wrap gives daily carry to weekday
// - Afternoon flag: 0 morning, 1 afternoon
`timescale 1ns/1ps

module rtcmh_counters (
    input wire logic core_clk, // 40 MHz clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic minute_tick, // Once-per-minute carry, one cycle
    input wire logic [3:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    output logic [31:0] avs_readdata, // Read data, registered
    output logic avs_waitrequest, // Low when answer stands
    output logic day_carry, // Daily carry to weekday counter
    output logic update_in_progress // Busy flag copy
);
    import rtcmh_pkg::*;

    // ------------------------------------------------------------
    // Behaviour summary
    // ------------------------------------------------------------
    // The counters count only on minute_tick, which the seconds
    // counter raises for one core_clk cycle per minute. The hour
    // counter moves in the same update as the minute wrap, so the
    // two never disagree for a cycle.
    // Register access takes one wait cycle: a request seen while the
    // answer state is idle is taken at that edge, and waitrequest is
    // low during the next cycle, with read data standing beside it.
    // A write that meets a tick is held back one cycle; the master
    // keeps its request up, so nothing is lost.
    // Limitation: switching from 24-hour to 12-hour range while the
    // hour is above 11 leaves the hour as it is until software
    // writes a legal value; the range check relaxes for one cycle.
    // Trade-off: the busy flag is stretched a fixed two cycles after
    // the tick instead of tracking the real update length, which
    // keeps the logic small at the price of a slightly longer flag.

    // ------------------------------------------------------------
    // State and bus bundling
    // ------------------------------------------------------------
    rtcmh_state_t state_reg; // Registered state
    rtcmh_state_t state_next; // Next state
    rtcmh_bus_req_t req; // Bundled bus request
    logic min_wrap; // Minute 59 -> 00 this tick
    logic hr_wrap; // Hour at top this tick
    logic [7:0] hr_top; // Top of selected hour range
    logic [7:0] min_rd; // minute_count read image
    logic [7:0] hr_rd; // hour_count read image
    logic busy; // Update in progress

    assign req = '{avs_address, avs_read, avs_write, avs_writedata};

    // Busy while a tick is being applied and for a short stretch after
    assign busy = minute_tick || (state_reg.busy_cnt != 2'h0);
    assign min_wrap = (state_reg.minute == {RTCMH_MIN_TENS_MAX,
                                            RTCMH_UNITS_MAX});
    assign hr_top = state_reg.mode24 ? RTCMH_HR24_TOP
                                     : RTCMH_HR12_TOP;
    assign hr_wrap = ({2'b00, state_reg.hour} == hr_top);
    assign min_rd = {busy, state_reg.minute};
    assign hr_rd = {busy, 1'b0, state_reg.hour};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.day_carry = 1'b0;
        // Busy stretch counts down so the flag covers the update edge
        if (minute_tick) begin
            state_next.busy_cnt = RTCMH_BUSY_CYC;
        end else if (state_reg.busy_cnt != 2'h0) begin
            state_next.busy_cnt = state_reg.busy_cnt - 2'h1;
        end
        // Counting has priority over a software write in the same cycle
        if (minute_tick) begin
            if (min_wrap) begin
                state_next.minute = RTCMH_MIN_RST;
                if (hr_wrap) begin
                    state_next.hour = RTCMH_HR_RST;
                    state_next.day_carry = 1'b1;
                    state_next.day_cnt = state_reg.day_cnt + 8'h01;
                    // Twelve-hour wrap flips morning/afternoon
                    if (!state_reg.mode24) begin
                        state_next.pm = ~state_reg.pm;
                    end
                end else if (state_reg.hour[3:0] == RTCMH_UNITS_MAX) begin
                    state_next.hour[3:0] = 4'h0;
                    state_next.hour[5:4] = state_reg.hour[5:4] + 2'h1;
                end else begin
                    state_next.hour[3:0] = state_reg.hour[3:0] + 4'h1;
                end
            end else if (state_reg.minute[3:0] == RTCMH_UNITS_MAX) begin
                state_next.minute[3:0] = 4'h0;
                state_next.minute[6:4] = state_reg.minute[6:4] + 3'h1;
            end else begin
                state_next.minute[3:0] = state_reg.minute[3:0] + 4'h1;
            end
        end else if (req.write && state_reg.bus_st == RTCMH_IDLE) begin
            case (req.address)
                RTCMH_OFS_MINUTE: begin
                    // Out-of-range BCD writes are ignored
                    if (req.writedata[6:4] <= RTCMH_MIN_TENS_MAX &&
                        req.writedata[3:0] <= RTCMH_UNITS_MAX) begin
                        state_next.minute = req.writedata[6:0];
                    end
                end
                RTCMH_OFS_HOUR: begin
                    if (req.writedata[3:0] <= RTCMH_UNITS_MAX &&
                        {2'b00, req.writedata[5:0]} <= hr_top) begin
                        state_next.hour = req.writedata[5:0];
                    end
                end
                RTCMH_OFS_CTRL: begin
                    state_next.mode24 = req.writedata[RTCMH_MODE_BIT];
                    state_next.pm = req.writedata[RTCMH_PM_BIT];
                end
                default: begin
                end
            endcase
        end
        // Bus answer: one wait cycle, then the answer stands one cycle
        case (state_reg.bus_st)
            RTCMH_IDLE: begin
                if (req.read || (req.write && !minute_tick)) begin
                    state_next.bus_st = RTCMH_DONE;
                    case (req.address)
                        RTCMH_OFS_MINUTE: state_next.rdata = {24'h0, min_rd};
                        RTCMH_OFS_HOUR: state_next.rdata = {24'h0, hr_rd};
                        RTCMH_OFS_CTRL: state_next.rdata = {24'h0, 1'b0,
                            state_reg.mode24, state_reg.pm, 5'h00};
                        RTCMH_OFS_STAT: state_next.rdata = {24'h0,
                            state_reg.day_cnt};
                        default: state_next.rdata = 32'h0; // Unmapped
                    endcase
                end
            end
            RTCMH_DONE: begin
                state_next.bus_st = RTCMH_IDLE;
            end
            default: begin
                state_next.bus_st = RTCMH_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_readdata = state_reg.rdata;
    assign avs_waitrequest = (state_reg.bus_st != RTCMH_DONE);
    assign day_carry = state_reg.day_carry;
    assign update_in_progress = busy;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_minute_step: assert property (minute_tick && !min_wrap &&
        state_reg.minute[3:0] != 4'h9 |=> state_reg.minute[3:0] ==
        $past(state_reg.minute[3:0]) + 4'h1)
        else $error("minute did not step");
    a_minute_range: assert property (state_reg.minute[3:0] <= 4'h9 &&
        state_reg.minute[6:4] <= 3'h5)
        else $error("minute out of range");
    a_minute_units: assert property (minute_tick && !min_wrap &&
        state_reg.minute[3:0] == 4'h9 |=> state_reg.minute[3:0] == 4'h0
        && state_reg.minute[6:4] == $past(state_reg.minute[6:4]) + 3'h1)
        else $error("minute units wrap wrong");
    a_minute_tens: assert property (state_reg.minute[6:4] <= 3'h5)
        else $error("minute tens over 5");
    a_busy_flag: assert property (minute_tick |-> busy ##1 busy)
        else $error("busy not raised");
    a_hour_step: assert property (minute_tick && min_wrap && !hr_wrap
        |=> state_reg.hour != $past(state_reg.hour))
        else $error("hour did not advance");
    a_hour_range: assert property (!state_reg.mode24 |->
        state_reg.hour <= 6'h11 || $past(state_reg.mode24))
        else $error("hour beyond 12-hour range");
    a_hour_units: assert property (state_reg.hour[3:0] <= 4'h9)
        else $error("hour units over 9");
    a_hour_tens: assert property (state_reg.hour[5:4] <= 2'h2)
        else $error("hour tens over 2");
    a_hour_bit6: assert property (hr_rd[6] == 1'b0)
        else $error("hour bit 6 set");
    a_mode_top: assert property (state_reg.mode24 && minute_tick &&
        min_wrap && state_reg.hour == 6'h23 |=> state_reg.hour == 6'h00)
        else $error("24-hour wrap wrong");
    a_day_carry: assert property (minute_tick && min_wrap && hr_wrap
        |=> day_carry && state_reg.hour == 6'h00)
        else $error("daily carry missing");
    a_pm_toggle: assert property (minute_tick && min_wrap && hr_wrap &&
        !state_reg.mode24 |=> state_reg.pm != $past(state_reg.pm))
        else $error("afternoon flag not toggled");
    a_minute_wrap: assert property (minute_tick && min_wrap |=>
        state_reg.minute == 7'h00)
        else $error("minute wrap wrong");

    c_hour_wrap: cover property (minute_tick && min_wrap && hr_wrap);
    c_min_wrap: cover property (minute_tick && min_wrap);
    c_bus_read: cover property (avs_read && !avs_waitrequest);
    c_write_tick: cover property (avs_write && minute_tick);
    c_busy_read: cover property (avs_read && update_in_progress &&
        state_reg.bus_st == RTCMH_IDLE);

    // ------------------------------------------------------------
    // Busy flag timing
    // ------------------------------------------------------------
    // Stretch loads its full length with every tick
    a_busy_stretch: assert property (minute_tick |=>
        state_reg.busy_cnt == RTCMH_BUSY_CYC)
        else $error("busy stretch not loaded");

    // Stretch counts down by one per cycle without a tick
    a_busy_count: assert property (!minute_tick &&
        state_reg.busy_cnt != 2'h0 |=>
        state_reg.busy_cnt == $past(state_reg.busy_cnt) - 2'h1)
        else $error("busy stretch not counting");

    // Flag low once the stretch has run out
    a_busy_clear: assert property (!minute_tick &&
        state_reg.busy_cnt == 2'h0 |-> !update_in_progress)
        else $error("busy stuck high");

    // ------------------------------------------------------------
    // Counter holding and stepping
    // ------------------------------------------------------------
    // Minute moves only on a tick or a minute write
    a_minute_hold: assert property (!minute_tick &&
        !(req.write && req.address == RTCMH_OFS_MINUTE) |=>
        state_reg.minute == $past(state_reg.minute))
        else $error("minute moved without cause");

    // Hour moves only on an hourly carry or an hour write
    a_hour_hold: assert property (!(minute_tick && min_wrap) &&
        !(req.write && req.address == RTCMH_OFS_HOUR) |=>
        state_reg.hour == $past(state_reg.hour))
        else $error("hour moved without cause");

    // Hour units step by one on a plain hourly carry
    a_hour_units_step: assert property (minute_tick &&
        min_wrap && !hr_wrap && state_reg.hour[3:0] != 4'h9 |=>
        state_reg.hour[3:0] == $past(state_reg.hour[3:0]) + 4'h1)
        else $error("hour units did not step");

    // 24-hour range never passes 23
    a_hour_range_24: assert property (state_reg.mode24 |->
        state_reg.hour <= 6'h23)
        else $error("hour beyond 24-hour range");

    // Tens of two allow units up to three only
    a_hour_tens_two: assert property (state_reg.hour[5:4] == 2'h2 |->
        state_reg.hour[3:0] <= 4'h3)
        else $error("hour above 23");

    // Afternoon flag holds in 24-hour mode unless written
    a_pm_hold: assert property (state_reg.mode24 &&
        !(req.write && req.address == RTCMH_OFS_CTRL) |=>
        state_reg.pm == $past(state_reg.pm))
        else $error("afternoon flag moved in 24-hour mode");

    // ------------------------------------------------------------
    // Daily carry
    // ------------------------------------------------------------
    // Daily carry is a single-cycle pulse
    a_day_pulse: assert property (day_carry |=> !day_carry)
        else $error("daily carry longer than one cycle");

    // Daily carry comes only from an hour wrap
    a_day_cause: assert property (day_carry |->
        $past(minute_tick && min_wrap && hr_wrap))
        else $error("daily carry without hour wrap");

    // ------------------------------------------------------------
    // Register bus answer
    // ------------------------------------------------------------
    // Answer stands exactly one cycle
    a_wait_one: assert property (!avs_waitrequest |=>
        avs_waitrequest)
        else $error("answer stood too long");

    // An idle request is answered in the next cycle
    a_wait_answer: assert property ((avs_read ||
        (avs_write && !minute_tick)) &&
        state_reg.bus_st == RTCMH_IDLE |=> !avs_waitrequest)
        else $error("request not answered");

    // Write meeting a tick is held back one cycle
    a_write_defer: assert property (minute_tick && avs_write &&
        state_reg.bus_st == RTCMH_IDLE |=> avs_waitrequest)
        else $error("write not deferred behind tick");

    // Upper read bits always zero
    a_rdata_upper: assert property (!avs_waitrequest |->
        avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits set");

endmodule : rtcmh_counters

// file: rtcmh_pkg.sv
// Package for the minute and hour counters: offsets, fields, types
package rtcmh_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the Avalon word bus)
    // ------------------------------------------------------------
    localparam logic [3:0] RTCMH_OFS_MINUTE = 4'h0; // minute_count
    localparam logic [3:0] RTCMH_OFS_HOUR = 4'h4; // hour_count
    localparam logic [3:0] RTCMH_OFS_CTRL = 4'h8; // mode and afternoon
    localparam logic [3:0] RTCMH_OFS_STAT = 4'hC; // daily carry count

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RTCMH_BUSY_BIT = 7; // Busy flag in both counters
    localparam int RTCMH_MODE_BIT = 6; // 24-hour select in control
    localparam int RTCMH_PM_BIT = 5; // Afternoon flag in control

    // ------------------------------------------------------------
    // Counting limits and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] RTCMH_UNITS_MAX = 4'h9; // Units digit top
    localparam logic [2:0] RTCMH_MIN_TENS_MAX = 3'h5; // Minute tens top
    localparam logic [7:0] RTCMH_HR12_TOP = 8'h11; // 12-hour top, BCD
    localparam logic [7:0] RTCMH_HR24_TOP = 8'h23; // 24-hour top, BCD
    localparam logic [6:0] RTCMH_MIN_RST = 7'h00; // Minute after reset
    localparam logic [5:0] RTCMH_HR_RST = 6'h00; // Hour after reset
    localparam logic [1:0] RTCMH_BUSY_CYC = 2'h2; // Busy stretch cycles

    // ------------------------------------------------------------
    // Bus request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] address; // Byte address
        logic read; // Read strobe
        logic write; // Write strobe
        logic [31:0] writedata; // Write data
    } rtcmh_bus_req_t;

    // Bus answer states
    typedef enum logic [1:0] {
        RTCMH_IDLE = 2'b00, // No answer pending
        RTCMH_DONE = 2'b01 // Answer stands this cycle
    } rtcmh_bus_st_t;

    // All state of the block
    typedef struct packed {
        logic [6:0] minute; // BCD minute, tens in [6:4]
        logic [5:0] hour; // BCD hour, tens in [5:4]
        logic mode24; // 1 selects 24-hour range
        logic pm; // Afternoon flag
        logic [1:0] busy_cnt; // Remaining busy cycles
        logic [7:0] day_cnt; // Daily carries seen
        logic day_carry; // Daily carry pulse
        rtcmh_bus_st_t bus_st; // Bus answer state
        logic [31:0] rdata; // Read data
    } rtcmh_state_t;

endpackage : rtcmh_pkg

// file: rtcmh_tb.sv
// Self-checking testbench for the minute and hour counters
`timescale 1ns/1ps

module testbench;
    import rtcmh_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic core_clk; // 40 MHz clock
    logic srst; // Synchronous reset, active high
    logic minute_tick; // Minute carry pulse
    rtcmh_bus_req_t req; // Bus request carrier
    logic [31:0] avs_readdata; // Read data from the block
    logic avs_waitrequest; // Slave stall
    logic day_carry; // Daily carry pulse
    logic update_in_progress; // Busy flag
    int n_errors; // Mismatches seen
    int cmp_count; // Comparisons made
    int n_day; // Daily carry pulses counted
    logic [31:0] rd; // Data of the last read

    rtcmh_counters u_dut (
        .core_clk(core_clk), // Clock
        .srst(srst), // Reset
        .minute_tick(minute_tick), // Minute carry
        .avs_address(req.address), // Address
        .avs_read(req.read), // Read strobe
        .avs_write(req.write), // Write strobe
        .avs_writedata(req.writedata), // Write data
        .avs_readdata(avs_readdata), // Read data
        .avs_waitrequest(avs_waitrequest), // Stall
        .day_carry(day_carry), // Daily carry
        .update_in_progress(update_in_progress) // Busy
    );

    // Free-running 25 ns clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Count daily carry pulses as they stand at each edge
    always @(posedge core_clk) begin
        if (day_carry === 1'b1) n_day <= n_day + 1;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One Avalon transfer: hold until waitrequest is sampled low
    task automatic bus(input logic [3:0] a, input logic wr_en,
                       input logic [31:0] d);
        int n;
        n = 0;
        req <= '{address: a, read: ~wr_en, write: wr_en, writedata: d};
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
        req <= '{address: a, read: 1'b0, write: 1'b0, writedata: d};
        // Let an edge pass so the next request is a fresh assignment
        @(posedge core_clk);
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp,
                        input string name);
        bus(a, 1'b0, 32'h0);
        chk(name, exp, rd);
    endtask : rchk

    // One minute carry; busy must rise with it and clear afterwards
    task automatic tick;
        minute_tick <= 1'b1;
        @(posedge core_clk);
        minute_tick <= 1'b0;
        #1 chk("busy", 32'h1, {31'h0, update_in_progress});
        repeat (3) @(posedge core_clk);
        #1 chk("busy idle", 32'h0, {31'h0, update_in_progress});
        @(posedge core_clk);
    endtask : tick

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        n_errors++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        minute_tick = 1'b0;
        req = '0;
        n_errors = 0;
        cmp_count = 0;
        n_day = 0;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rchk(RTCMH_OFS_MINUTE, 32'h00, "minute after reset");
        rchk(RTCMH_OFS_HOUR, 32'h00, "hour after reset");
        rchk(RTCMH_OFS_CTRL, 32'h00, "control after reset");
        rchk(4'h2, 32'h00, "unmapped read");
        // Units wrap into tens, then 59 wraps and carries the hour
        wr(RTCMH_OFS_MINUTE, 32'h09);
        tick();
        rchk(RTCMH_OFS_MINUTE, 32'h10, "minute units wrap");
        wr(RTCMH_OFS_MINUTE, 32'h58);
        tick();
        rchk(RTCMH_OFS_MINUTE, 32'h59, "minute step");
        tick();
        rchk(RTCMH_OFS_MINUTE, 32'h00, "minute 59 wrap");
        rchk(RTCMH_OFS_HOUR, 32'h01, "hour carry");
        // Out-of-range minute writes leave the value alone
        wr(RTCMH_OFS_MINUTE, 32'h60);
        rchk(RTCMH_OFS_MINUTE, 32'h00, "minute 60 refused");
        wr(RTCMH_OFS_MINUTE, 32'h4A);
        rchk(RTCMH_OFS_MINUTE, 32'h00, "minute 4A refused");
        // Hour units wrap into tens
        wr(RTCMH_OFS_HOUR, 32'h09);
        wr(RTCMH_OFS_MINUTE, 32'h59);
        tick();
        rchk(RTCMH_OFS_HOUR, 32'h10, "hour units wrap");
        // 12-hour top wraps, flips afternoon, gives the daily carry
        wr(RTCMH_OFS_HOUR, 32'h11);
        wr(RTCMH_OFS_MINUTE, 32'h59);
        tick();
        rchk(RTCMH_OFS_HOUR, 32'h00, "12h wrap");
        rchk(RTCMH_OFS_CTRL, 32'h20, "afternoon flag");
        rchk(RTCMH_OFS_STAT, 32'h01, "daily carries");
        wr(RTCMH_OFS_HOUR, 32'h12);
        rchk(RTCMH_OFS_HOUR, 32'h00, "12h range");
        // 24-hour range, tens limit and reserved bit 6
        wr(RTCMH_OFS_CTRL, 32'h40);
        wr(RTCMH_OFS_HOUR, 32'h23);
        rchk(RTCMH_OFS_HOUR, 32'h23, "24h top");
        wr(RTCMH_OFS_HOUR, 32'h24);
        rchk(RTCMH_OFS_HOUR, 32'h23, "hour 24 refused");
        wr(RTCMH_OFS_HOUR, 32'h45);
        rchk(RTCMH_OFS_HOUR, 32'h05, "hour bit 6");
        wr(RTCMH_OFS_HOUR, 32'h23);
        wr(RTCMH_OFS_MINUTE, 32'h59);
        tick();
        rchk(RTCMH_OFS_HOUR, 32'h00, "24h wrap");
        rchk(RTCMH_OFS_CTRL, 32'h40, "24h keeps flag");
        rchk(RTCMH_OFS_STAT, 32'h02, "daily carries");
        chk("day pulses", 32'h2, n_day);
        // A read in the update cycle shows busy in bit 7
        fork
            tick();
            bus(RTCMH_OFS_MINUTE, 1'b0, 32'h0);
        join
        chk("busy bit", 32'h80, rd & 32'h80);
        // A write meeting a carry is applied after the count
        fork
            tick();
            wr(RTCMH_OFS_MINUTE, 32'h30);
        join
        rchk(RTCMH_OFS_MINUTE, 32'h30, "write after carry");
        complete_run();
    end

endmodule : testbench
